/* rtl/prom_prog_defs.svh */
// Purpose: constants for the PROM programming controller
// Assumes: 100 MHz core clock
// Notes: times in their own units, cycle counts derived from them
`ifndef PROM_PROG_DEFS_SVH
`define PROM_PROG_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define PP_CLK_PS 10000
// setup of address, data, supplies and mode pins before a strobe
`define PP_T_SETUP_PS 2000000
// hold of address and data after the chip-enable strobe rises
`define PP_T_HOLD_PS 2000000
// longest strobe or address to data-out time of the device
`define PP_T_ACCESS_PS 2000000
// longest data float time after the output strobe rises
`define PP_T_FLOAT_PS 130000
// initial program pulse, nominal 1 ms (0.95 to 1.05 ms allowed)
`define PP_T_INIT_PULSE_US 1000
// extra pulse unit, 3 ms per attempt (2.85 to 78.75 ms allowed)
`define PP_T_EXTRA_UNIT_US 3000
// least times round up to whole cycles
`define PP_SETUP_CYC ((`PP_T_SETUP_PS + `PP_CLK_PS - 1) / `PP_CLK_PS)
`define PP_HOLD_CYC ((`PP_T_HOLD_PS + `PP_CLK_PS - 1) / `PP_CLK_PS)
`define PP_ACCESS_CYC ((`PP_T_ACCESS_PS + `PP_CLK_PS - 1) / `PP_CLK_PS)
`define PP_FLOAT_CYC ((`PP_T_FLOAT_PS + `PP_CLK_PS - 1) / `PP_CLK_PS)
`define PP_INIT_PULSE_CYC (`PP_T_INIT_PULSE_US * (1000000 / `PP_CLK_PS))
`define PP_EXTRA_UNIT_CYC (`PP_T_EXTRA_UNIT_US * (1000000 / `PP_CLK_PS))

// ----------------------------------------------------------------
// sizes and limits
// ----------------------------------------------------------------
`define PP_ADDR_W 14
`define PP_DATA_W 8
`define PP_CNT_W 20
`define PP_TRY_W 5
`define PP_MAX_TRIES 5'h19

`endif

/* rtl/prom_prog_pkg.sv */
// Purpose: types for the PROM programming controller
// Assumes: constants come from prom_prog_defs.svh
// Notes: state encoding left to the tools
package prom_prog_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_FETCH,
    ST_W_SETUP,
    ST_W_PULSE,
    ST_W_HOLD,
    ST_V_FLOAT,
    ST_V_ACCESS,
    ST_X_SETUP,
    ST_X_PULSE,
    ST_X_HOLD,
    ST_NEXT,
    ST_R_SETUP,
    ST_R_ACCESS,
    ST_END
  } state_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_WRITE,
    OP_READ
  } op_t;

endpackage : prom_prog_pkg

/* rtl/prom_programmer.sv */
// Purpose: external programmer driving the on-chip PROM pins
// Assumes: user inputs synchronous to CORE_CLK; supplies switched
//   by VPP_HIGH and VDD_PROG level requests
// Notes: byte-serial write with pulse, verify and over-program
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_defs.svh"

module prom_programmer #(
  parameter int INIT_PULSE_CYC = `PP_INIT_PULSE_CYC,
  parameter int EXTRA_UNIT_CYC = `PP_EXTRA_UNIT_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic START_WRITE,
  input wire logic START_READ,
  input wire logic [`PP_ADDR_W-1:0] START_ADDR,
  input wire logic [`PP_ADDR_W-1:0] END_ADDR,
  output logic DATA_REQ,
  input wire logic DATA_VALID,
  input wire logic [`PP_DATA_W-1:0] WR_DATA,
  output logic [`PP_DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic BUSY,
  output logic DONE,
  output logic FAIL,
  output logic [`PP_ADDR_W-1:0] FAIL_ADDR,
  output logic [`PP_ADDR_W-1:0] PROM_ADDR,
  output logic TOP_ADDRESS_BIT,
  output logic PROG_ENTRY_HIGH_PIN,
  output logic PROG_ENTRY_LOW_PIN,
  output logic DEV_RESET_N,
  output logic CE_N,
  output logic OE_N,
  output logic [`PP_DATA_W-1:0] PROM_DATA_O,
  output logic PROM_DATA_OE_N,
  input wire logic [`PP_DATA_W-1:0] PROM_DATA_I,
  output logic VPP_HIGH,
  output logic VDD_PROG
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // load value for the cycle counter (count runs down to 1)
  function automatic logic [`PP_CNT_W-1:0] cyc(input int n);
    cyc = `PP_CNT_W'(n);
  endfunction : cyc

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prom_prog_pkg::state_t state_reg, state_next;
  prom_prog_pkg::op_t op_reg, op_next;
  logic [`PP_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`PP_TRY_W-1:0] try_reg, try_next;
  logic [`PP_TRY_W-1:0] unit_reg, unit_next;
  logic [`PP_ADDR_W-1:0] addr_reg, addr_next;
  logic [`PP_ADDR_W-1:0] end_reg, end_next;
  logic [`PP_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`PP_DATA_W-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;
  logic drive_reg, drive_next;
  logic vpp_reg, vpp_next;
  logic vdd_reg, vdd_next;
  logic mode_reg, mode_next;
  logic cnt_last;

  assign cnt_last = (cnt_reg == cyc(1));

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = (cnt_reg > cyc(1)) ? cnt_reg - cyc(1) : cnt_reg;
    try_next = try_reg;
    unit_next = unit_reg;
    addr_next = addr_reg;
    end_next = end_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    done_next = 1'b0;
    fail_next = fail_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    drive_next = drive_reg;
    vpp_next = vpp_reg;
    vdd_next = vdd_reg;
    mode_next = mode_reg;
    unique case (state_reg)
      prom_prog_pkg::ST_IDLE: begin
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        drive_next = 1'b0;
        if (START_WRITE) begin
          op_next = prom_prog_pkg::OP_WRITE;
          fail_next = 1'b0;
          addr_next = START_ADDR;
          end_next = END_ADDR;
          vpp_next = 1'b1;
          vdd_next = 1'b1;
          mode_next = 1'b1;
          cnt_next = cyc(`PP_SETUP_CYC);
          state_next = prom_prog_pkg::ST_SETTLE;
        end else if (START_READ) begin
          op_next = prom_prog_pkg::OP_READ;
          addr_next = START_ADDR;
          vpp_next = 1'b0;
          vdd_next = 1'b0;
          mode_next = 1'b1;
          cnt_next = cyc(`PP_SETUP_CYC);
          state_next = prom_prog_pkg::ST_SETTLE;
        end
      end
      prom_prog_pkg::ST_SETTLE: begin
        // supplies and entry pins settle before any strobe
        if (cnt_last) begin
          if (op_reg == prom_prog_pkg::OP_WRITE) begin
            state_next = prom_prog_pkg::ST_FETCH;
          end else begin
            ce_n_next = 1'b0;
            oe_n_next = 1'b0;
            cnt_next = cyc(`PP_ACCESS_CYC);
            state_next = prom_prog_pkg::ST_R_ACCESS;
          end
        end
      end
      prom_prog_pkg::ST_FETCH: begin
        // new byte: take data, restart attempt count
        if (DATA_VALID) begin
          wdata_next = WR_DATA;
          try_next = '0;
          cnt_next = cyc(`PP_SETUP_CYC);
          state_next = prom_prog_pkg::ST_W_SETUP;
        end
      end
      prom_prog_pkg::ST_W_SETUP: begin
        drive_next = (cnt_reg < cyc(`PP_SETUP_CYC - `PP_FLOAT_CYC));
        if (cnt_last) begin
          ce_n_next = 1'b0;
          try_next = try_reg + `PP_TRY_W'(1);
          cnt_next = cyc(INIT_PULSE_CYC);
          state_next = prom_prog_pkg::ST_W_PULSE;
        end
      end
      prom_prog_pkg::ST_W_PULSE: begin
        if (cnt_last) begin
          ce_n_next = 1'b1;
          cnt_next = cyc(`PP_HOLD_CYC);
          state_next = prom_prog_pkg::ST_W_HOLD;
        end
      end
      prom_prog_pkg::ST_W_HOLD: begin
        if (cnt_last) begin
          drive_next = 1'b0;
          cnt_next = cyc(`PP_SETUP_CYC);
          state_next = prom_prog_pkg::ST_V_FLOAT;
        end
      end
      prom_prog_pkg::ST_V_FLOAT: begin
        if (cnt_last) begin
          oe_n_next = 1'b0;
          cnt_next = cyc(`PP_ACCESS_CYC);
          state_next = prom_prog_pkg::ST_V_ACCESS;
        end
      end
      prom_prog_pkg::ST_V_ACCESS: begin
        if (cnt_last) begin
          oe_n_next = 1'b1;
          cnt_next = cyc(`PP_SETUP_CYC);
          if (PROM_DATA_I == wdata_reg) begin
            unit_next = try_reg;
            state_next = prom_prog_pkg::ST_X_SETUP;
          end else if (try_reg >= `PP_MAX_TRIES) begin
            fail_next = 1'b1;
            state_next = prom_prog_pkg::ST_END;
          end else begin
            state_next = prom_prog_pkg::ST_W_SETUP;
          end
        end
      end
      prom_prog_pkg::ST_X_SETUP: begin
        // wait for data float, then drive data again
        drive_next = (cnt_reg < cyc(`PP_SETUP_CYC - `PP_FLOAT_CYC));
        if (cnt_last) begin
          ce_n_next = 1'b0;
          cnt_next = cyc(EXTRA_UNIT_CYC);
          state_next = prom_prog_pkg::ST_X_PULSE;
        end
      end
      prom_prog_pkg::ST_X_PULSE: begin
        // one unit per attempt used: 1 to 25 units
        if (cnt_last) begin
          if (unit_reg == `PP_TRY_W'(1)) begin
            ce_n_next = 1'b1;
            cnt_next = cyc(`PP_HOLD_CYC);
            state_next = prom_prog_pkg::ST_X_HOLD;
          end else begin
            unit_next = unit_reg - `PP_TRY_W'(1);
            cnt_next = cyc(EXTRA_UNIT_CYC);
          end
        end
      end
      prom_prog_pkg::ST_X_HOLD: begin
        if (cnt_last) begin
          drive_next = 1'b0;
          state_next = prom_prog_pkg::ST_NEXT;
        end
      end
      prom_prog_pkg::ST_NEXT: begin
        if (addr_reg == end_reg) begin
          state_next = prom_prog_pkg::ST_END;
        end else begin
          addr_next = addr_reg + `PP_ADDR_W'(1);
          cnt_next = cyc(`PP_SETUP_CYC);
          state_next = prom_prog_pkg::ST_SETTLE;
        end
      end
      prom_prog_pkg::ST_R_ACCESS: begin
        if (cnt_last) begin
          rdata_next = PROM_DATA_I;
          rvalid_next = 1'b1;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
          state_next = prom_prog_pkg::ST_END;
        end
      end
      prom_prog_pkg::ST_END: begin
        // strobes idle, supplies off, hand back to user
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        drive_next = 1'b0;
        vpp_next = 1'b0;
        vdd_next = 1'b0;
        mode_next = 1'b0;
        done_next = 1'b1;
        op_next = prom_prog_pkg::OP_NONE;
        state_next = prom_prog_pkg::ST_IDLE;
      end
      default: begin
        state_next = prom_prog_pkg::ST_END;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= prom_prog_pkg::ST_IDLE;
      op_reg <= prom_prog_pkg::OP_NONE;
      cnt_reg <= '0;
      try_reg <= '0;
      unit_reg <= '0;
      addr_reg <= '0;
      end_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      drive_reg <= 1'b0;
      vpp_reg <= 1'b0;
      vdd_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      try_reg <= try_next;
      unit_reg <= unit_next;
      addr_reg <= addr_next;
      end_reg <= end_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      drive_reg <= drive_next;
      vpp_reg <= vpp_next;
      vdd_reg <= vdd_next;
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // handshake request is combinational
  assign DATA_REQ = (state_reg == prom_prog_pkg::ST_FETCH);
  assign BUSY = (state_reg != prom_prog_pkg::ST_IDLE);
  assign RD_DATA = rdata_reg;
  assign RD_VALID = rvalid_reg;
  assign DONE = done_reg;
  assign FAIL = fail_reg;
  assign FAIL_ADDR = addr_reg;
  assign PROM_ADDR = addr_reg;
  // mode entry pins while a session runs
  assign TOP_ADDRESS_BIT = 1'b0;
  assign PROG_ENTRY_HIGH_PIN = mode_reg;
  assign PROG_ENTRY_LOW_PIN = 1'b0;
  assign DEV_RESET_N = 1'b0;
  assign CE_N = ce_n_reg;
  assign OE_N = oe_n_reg;
  assign PROM_DATA_O = wdata_reg;
  assign PROM_DATA_OE_N = ~drive_reg;
  assign VPP_HIGH = vpp_reg;
  assign VDD_PROG = vdd_reg;

endmodule : prom_programmer

`default_nettype wire

/* verif/prom_programmer_assertions.sv */
// Purpose: checker for the PROM programming controller pins
// Assumes: CLK_EN high through write sessions
// Notes: pulse widths counted in enabled edges
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_defs.svh"

module prom_programmer_checker #(
  parameter int INIT_PULSE_CYC = 50,
  parameter int EXTRA_UNIT_CYC = 100
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic BUSY,
  input wire logic FAIL,
  input wire logic RD_VALID,
  input wire logic [`PP_DATA_W-1:0] RD_DATA,
  input wire logic [`PP_ADDR_W-1:0] PROM_ADDR,
  input wire logic TOP_ADDRESS_BIT,
  input wire logic PROG_ENTRY_HIGH_PIN,
  input wire logic PROG_ENTRY_LOW_PIN,
  input wire logic DEV_RESET_N,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic PROM_DATA_OE_N,
  input wire logic [`PP_DATA_W-1:0] PROM_DATA_I,
  input wire logic VPP_HIGH
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [19:0] width_reg, width_next;
  logic [4:0] tries_reg, tries_next;
  logic ce_q_reg, oe_q_reg, pend_reg, pend_next;
  wire ce_rise = CE_N && !ce_q_reg && VPP_HIGH;
  wire is_init = int'(width_reg) == INIT_PULSE_CYC;

  // low width of the strobe, pulses per byte, verify owed
  always_comb begin
    width_next = CE_N ? 20'h0 : (CLK_EN ? width_reg + 20'h1 : width_reg);
    tries_next = tries_reg;
    pend_next = pend_reg;
    if (!BUSY) tries_next = 5'h0;
    else if (ce_rise) tries_next = is_init ? tries_reg + 5'h1 : 5'h0;
    if (!BUSY) pend_next = 1'b0;
    else if (ce_rise && is_init) pend_next = 1'b1;
    else if (!OE_N && oe_q_reg) pend_next = 1'b0;
  end

  // register the helper state
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      width_reg <= 20'h0;
      tries_reg <= 5'h0;
      ce_q_reg <= 1'b1;
      oe_q_reg <= 1'b1;
      pend_reg <= 1'b0;
    end else begin
      width_reg <= width_next;
      tries_reg <= tries_next;
      ce_q_reg <= CE_N;
      oe_q_reg <= OE_N;
      pend_reg <= pend_next;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  a_mode_pins_held: assert property (BUSY && $past(BUSY) |->
    PROG_ENTRY_HIGH_PIN && !PROG_ENTRY_LOW_PIN && !TOP_ADDRESS_BIT
    && !DEV_RESET_N) else $error("mode pins wrong in session");
  a_data_before_pulse: assert property ($fell(CE_N) && VPP_HIGH |->
    !PROM_DATA_OE_N && $past(PROM_DATA_OE_N, 8) == 1'b0)
    else $error("data not set up before pulse");
  a_first_pulse_len: assert property ($rose(CE_N) && VPP_HIGH
    && tries_reg == 5'h0 |-> is_init) else $error("initial pulse width");
  a_verify_gap: assert property ($fell(CE_N) && VPP_HIGH |-> !pend_reg)
    else $error("pulse without verify");
  a_extra_pulse_len: assert property ($rose(CE_N) && VPP_HIGH && !is_init
    |-> int'(width_reg) == int'(tries_reg) * EXTRA_UNIT_CYC
    && tries_reg != 5'h0) else $error("extra pulse width");
  a_retry_limit: assert property (tries_reg <= 5'h19 and
    ($rose(FAIL) |-> tries_reg == 5'h19)) else $error("attempt count");
  a_strobes_apart: assert property (VPP_HIGH |-> CE_N || OE_N)
    else $error("both strobes low at high voltage");
  a_read_strobes: assert property ($fell(OE_N) && !VPP_HIGH |->
    $fell(CE_N)) else $error("read strobes not together");
  a_read_capture: assert property ($rose(RD_VALID) |->
    RD_DATA == $past(PROM_DATA_I)) else $error("read data capture");
  a_addr_quiet: assert property ($changed(PROM_ADDR) |-> $past(CE_N)
    && $past(OE_N) && CE_N && OE_N) else $error("address moved in strobe");
  a_addr_step: assert property ($changed(PROM_ADDR) && VPP_HIGH
    && $past(VPP_HIGH) |-> PROM_ADDR == $past(PROM_ADDR) + 14'h1)
    else $error("address step");
  a_no_fight: assert property (!OE_N |-> PROM_DATA_OE_N)
    else $error("data driven under output strobe");
endmodule : prom_programmer_checker

bind prom_programmer prom_programmer_checker #(
  .INIT_PULSE_CYC(INIT_PULSE_CYC), .EXTRA_UNIT_CYC(EXTRA_UNIT_CYC)
) u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN), .BUSY(BUSY),
  .FAIL(FAIL), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
  .PROM_ADDR(PROM_ADDR), .TOP_ADDRESS_BIT(TOP_ADDRESS_BIT),
  .PROG_ENTRY_HIGH_PIN(PROG_ENTRY_HIGH_PIN),
  .PROG_ENTRY_LOW_PIN(PROG_ENTRY_LOW_PIN), .DEV_RESET_N(DEV_RESET_N),
  .CE_N(CE_N), .OE_N(OE_N), .PROM_DATA_OE_N(PROM_DATA_OE_N),
  .PROM_DATA_I(PROM_DATA_I), .VPP_HIGH(VPP_HIGH));
`default_nettype wire

/* verif/prom_device_model.sv */
// Purpose: behavioural PROM device on the programmer pins
// Assumes: need sets how many pulses a byte takes to stick
// Notes: clockless; answers after ACC_NS, floats to inverted data
`timescale 1ns/1ps
`default_nettype none

module prom_device_model #(
  parameter int ACC_NS = 900
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic vpp_high,
  input wire logic [13:0] addr,
  input wire logic top_bit,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n,
  input wire logic [4:0] need,
  output wire logic [7:0] pin
);
  logic [7:0] mem [0:16383];
  int cnt [0:16383];
  wire sel = !oe_n && !top_bit;
  wire logic [7:0] dev_q;

  // erased array, no pulses yet
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 8'hff;
      cnt[i] = 0;
    end
  end

  // drives only with output strobe low, late; else inverted float
  assign #(ACC_NS) dev_q = sel ? mem[addr] : ~mem[addr];
  // contention shows as unknown
  assign pin = !data_oe_n ? (sel ? 8'hxx : data_o) : dev_q;

  // program at end of write pulse, bits only cleared
  always @(posedge ce_n) begin
    if (vpp_high && oe_n && !top_bit) begin
      cnt[addr] = cnt[addr] + 1;
      if (cnt[addr] >= int'(need)) mem[addr] = mem[addr] & pin;
    end
  end
endmodule : prom_device_model
`default_nettype wire

/* verif/prom_programmer_bench.sv */
// Purpose: self-checking bench for the PROM programming controller
// Assumes: short pulse counts 50 and 100 cycles
// Notes: device model stands on the pins
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_defs.svh"

module prom_programmer_bench;
  logic clk, rst_n, clk_en, start_write, start_read, data_valid;
  logic [13:0] start_addr, end_addr, fail_addr, prom_addr;
  logic [7:0] wr_data, rd_data, data_o;
  logic data_req, rd_valid, busy, done, fail, top_bit, entry_hi, entry_lo;
  logic dev_rst_n, ce_n, oe_n, data_oe_n, vpp_high, vdd_prog;
  logic [4:0] need;
  wire logic [7:0] pin;
  int failures, num_checks;

  prom_programmer #(.INIT_PULSE_CYC(50), .EXTRA_UNIT_CYC(100)) u_dut (
    .CORE_CLK(clk), .RSTN(rst_n), .CLK_EN(clk_en),
    .START_WRITE(start_write), .START_READ(start_read),
    .START_ADDR(start_addr), .END_ADDR(end_addr), .DATA_REQ(data_req),
    .DATA_VALID(data_valid), .WR_DATA(wr_data), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .BUSY(busy), .DONE(done), .FAIL(fail),
    .FAIL_ADDR(fail_addr), .PROM_ADDR(prom_addr), .TOP_ADDRESS_BIT(top_bit),
    .PROG_ENTRY_HIGH_PIN(entry_hi), .PROG_ENTRY_LOW_PIN(entry_lo),
    .DEV_RESET_N(dev_rst_n), .CE_N(ce_n), .OE_N(oe_n), .PROM_DATA_O(data_o),
    .PROM_DATA_OE_N(data_oe_n), .PROM_DATA_I(pin), .VPP_HIGH(vpp_high),
    .VDD_PROG(vdd_prog));
  prom_device_model u_prom (.ce_n(ce_n), .oe_n(oe_n), .vpp_high(vpp_high),
    .addr(prom_addr), .top_bit(top_bit), .data_o(data_o),
    .data_oe_n(data_oe_n), .need(need), .pin(pin));

  // compare, count, report
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // one write session, bytes handed over on request
  task automatic run_write(input logic [13:0] s, e, input logic [7:0] b);
    int n, t;
    logic tk;
    n = 0;
    t = 0;
    start_addr = s;
    end_addr = e;
    start_write = 1'b1;
    @(posedge clk); #1;
    start_write = 1'b0;
    chk("write pins", 16'h7, 16'({vpp_high, vdd_prog, entry_hi}));
    while (done !== 1'b1 && t < 60000) begin
      tk = (data_req === 1'b1);
      data_valid = tk;
      wr_data = b + 8'(n);
      @(posedge clk); #1;
      if (tk) n++;
      t++;
    end
    chk("write done", 16'h1, 16'(done));
  endtask : run_write

  // one read, clock enable stuttering meanwhile
  task automatic read_one(input logic [13:0] a, input logic [7:0] exp);
    int t;
    logic seen;
    t = 0;
    seen = 1'b0;
    start_addr = a;
    start_read = 1'b1;
    @(posedge clk); #1;
    start_read = 1'b0;
    chk("read volts", 16'h1, 16'({vpp_high, vdd_prog, entry_hi}));
    while (done !== 1'b1 && t < 3000) begin
      clk_en = (t % 5 != 2);
      @(posedge clk); #1;
      if (rd_valid === 1'b1) seen = 1'b1;
      t++;
    end
    clk_en = 1'b1;
    chk("read done", 16'h1, 16'(done));
    chk("read data", 16'(exp), 16'(rd_data));
    chk("read valid", 16'h1, 16'(seen));
  endtask : read_one

  task automatic t_reset;
    chk("strobes idle", 16'h3, 16'({ce_n, oe_n}));
    chk("idle pins", 16'h0, 16'({busy, vpp_high, top_bit, entry_lo}));
    $display("test reset done");
  endtask : t_reset

  task automatic t_fail;
    need = 5'h1a;
    run_write(14'h0a, 14'h0b, 8'h33);
    chk("fail flag", 16'h1, 16'(fail));
    chk("fail addr", 16'h000a, 16'(fail_addr));
    chk("pulses", 16'd25, 16'(u_prom.cnt[10]));
    chk("aborted", 16'h0, 16'(u_prom.cnt[11]));
    $display("test fail done");
  endtask : t_fail

  task automatic t_write_ok;
    need = 5'h1;
    run_write(14'h3, 14'h5, 8'h5a);
    chk("fail clear", 16'h0, 16'(fail));
    for (int i = 0; i < 3; i++) begin
      chk("byte", 16'(8'h5a + 8'(i)), 16'(u_prom.mem[3 + i]));
      chk("pulses", 16'h2, 16'(u_prom.cnt[3 + i]));
    end
    chk("past end", 16'h0, 16'(u_prom.cnt[6]));
    $display("test write_ok done");
  endtask : t_write_ok

  task automatic t_retry_wrap;
    need = 5'h3;
    run_write(14'h3fff, 14'h0, 8'ha0);
    chk("byte top", 16'h00a0, 16'(u_prom.mem[16383]));
    chk("byte wrap", 16'h00a1, 16'(u_prom.mem[0]));
    chk("pulses top", 16'h4, 16'(u_prom.cnt[16383]));
    chk("pulses wrap", 16'h4, 16'(u_prom.cnt[0]));
    $display("test retry_wrap done");
  endtask : t_retry_wrap

  task automatic t_read;
    read_one(14'h3, 8'h5a);
    read_one(14'h5, 8'h5c);
    read_one(14'h3fff, 8'ha0);
    read_one(14'h2000, 8'hff);
    $display("test read done");
  endtask : t_read

  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1000000;
    failures++;
    stop_test();
  end

  // main sequence
  initial begin
    {rst_n, start_write, start_read, data_valid} = 4'h0;
    clk_en = 1'b1;
    start_addr = 14'h0;
    end_addr = 14'h0;
    wr_data = 8'h0;
    need = 5'h1;
    failures = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    @(posedge clk); #1;
    t_fail();
    t_write_ok();
    t_retry_wrap();
    t_read();
    stop_test();
  end
endmodule : prom_programmer_bench
`default_nettype wire
